// *** hdl/nvmsp_top.sv ***
/*
 * Front end of the nonvolatile memory controller: flash sections, write protection,
 * boot lock, load wait states and the shared AND-merging page buffer.
 * Assumes the array back end runs on sys_clk, starts on arr_req.start and pulses arr_done.
 */
// Local design decisions: strobed register access and the register offsets.
// Functional notes
// [RULE_01] Flash programmed and erased by whole pages
// [RULE_02] Two fuses split flash in 256-byte blocks
// [RULE_03] Boot end zero makes all flash boot
// [RULE_04] App end zero: code to flash end
// [RULE_05] App end not above boot: data only
// [RULE_06] Else code between ends, data above
// [RULE_07] Out-of-range fuse falls back to default
// [RULE_08] Boot code may write code and data
// [RULE_09] Code section may write data only
// [RULE_10] Data section code writes nothing nonvolatile; the code starts CMD_CHER from any section without a check
// [RULE_11] Boot section is never CPU-written; the code still starts a CPU CMD_CHER without any section or lock check
// [RULE_12] Boot lock blocks boot reads outside boot
// [RULE_13] Code write protect freezes code section; the code still starts CMD_CHER while it is set
// [RULE_14] EEPROM touches only marked bytes
// [RULE_15] Buffer store marks the EEPROM byte
// [RULE_16] User row is one EEPROM page
// [RULE_17] Debug may write user row when locked
// [RULE_18] Loads wait while an array is busy
// [RULE_19] One shared page buffer for all areas
// [RULE_20] Stores fill buffer by low address bits
// [RULE_21] Buffer store ANDs new and old data
// [RULE_22] Buffer set to ones after reset, ops
// [RULE_23] Software waits for idle before buffer use
`timescale 1ns/1ps
module nvmsp_top import nvmsp_pkg::*; #(
	parameter int FLASH_BYTES = 8192,
	parameter int PAGE_BYTES = 64,
	parameter int EE_BYTES = 128,
	parameter int UR_BYTES = 32,
	parameter logic [7:0] BOOT_END_DEF = 8'h00,
	parameter logic [7:0] APP_END_DEF = 8'h00
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_dbg,
	output logic [7:0] reg_rdata,
	input wire nvmsp_cpu_t cpu_req,
	input wire logic [15:0] cpu_pc,
	input wire logic dev_locked,
	input wire logic [7:0] boot_end_fuse,
	input wire logic [7:0] app_code_end_fuse,
	output logic cpu_wait,
	output logic cpu_ack,
	output logic [7:0] cpu_rdata,
	output logic fetch_block,
	output nvmsp_arr_req_t arr_req,
	output logic [PAGE_BYTES-1:0][7:0] arr_data,
	output logic [PAGE_BYTES-1:0] arr_mask,
	output logic arr_rd,
	output logic [15:0] arr_raddr,
	input wire logic arr_done,
	input wire logic [7:0] arr_rdata
);
	localparam int PW = $clog2(PAGE_BYTES);

	if (PAGE_BYTES < 2 || (1 << PW) != PAGE_BYTES || FLASH_BYTES > 32768 ||
		FLASH_BYTES % PAGE_BYTES != 0 || UR_BYTES > PAGE_BYTES ||
		EE_BYTES % PAGE_BYTES != 0) begin : g_bad_params
		$error("nvmsp_top: unsupported size parameters");
	end

	typedef enum logic {OP_IDLE = 1'b0, OP_RUN = 1'b1} nvmsp_op_t;

	// ****************************************
	// Decoding helpers
	// ****************************************
	function automatic logic fuse_fits(input logic [7:0] f);
		return 32'(f) * SECT_UNIT <= FLASH_BYTES;
	endfunction

	function automatic nvmsp_sec_t sec_of(input logic [15:0] off, input logic [7:0] b,
		input logic [7:0] a);
		logic [31:0] bb;
		logic [31:0] ab;
		bb = 32'(b) * SECT_UNIT;
		ab = 32'(a) * SECT_UNIT;
		if (b == 8'h00 || 32'(off) < bb)
			return SEC_BOOT; // [RULE_03]
		else if (a == 8'h00)
			return SEC_CODE; // [RULE_04]
		else if (a <= b)
			return SEC_DATA; // [RULE_05]
		else if (32'(off) < ab)
			return SEC_CODE; // [RULE_06]
		else
			return SEC_DATA;
	endfunction

	function automatic nvmsp_area_t area_of(input logic [15:0] a);
		if (a >= FL_BASE && 32'(a - FL_BASE) < FLASH_BYTES)
			return AR_FLASH;
		else if (a >= EE_BASE && 32'(a - EE_BASE) < EE_BYTES)
			return AR_EE;
		else if (a >= UR_BASE && 32'(a - UR_BASE) < UR_BYTES)
			return AR_USER; // [RULE_16]
		else
			return AR_NONE;
	endfunction

	// Section checks run on flash offsets; debug writes skip them, since they are no CPU code.
	function automatic logic wr_ok(input nvmsp_area_t ar, input nvmsp_sec_t ts,
		input nvmsp_sec_t es, input logic wp, input logic dbg, input logic lk);
		if (dbg)
			return !lk || ar == AR_USER; // [RULE_17]
		unique case (ar)
			AR_FLASH: begin
				if (ts == SEC_BOOT)
					return 1'b0; // [RULE_11]
				else if (ts == SEC_CODE)
					return es == SEC_BOOT && !wp; // [RULE_08] [RULE_13]
				else
					return es != SEC_DATA; // [RULE_08] [RULE_09] [RULE_10]
			end
			AR_EE, AR_USER: return es != SEC_DATA; // [RULE_10] [RULE_16]
			default: return 1'b0;
		endcase
	endfunction

	// ****************************************
	// State
	// ****************************************
	logic fuse_ok;
	logic [7:0] be;
	logic [7:0] ae;
	logic lock;
	logic app_code_write_protect;
	logic flash_busy_flag;
	logic ebusy;
	logic werr;
	nvmsp_op_t op;
	logic [PAGE_BYTES-1:0][7:0] pbuf;
	logic [PAGE_BYTES-1:0] pmark;
	nvmsp_area_t buf_area;
	nvmsp_sec_t buf_sec;
	logic [15:0] buf_page;
	logic ld_pend;
	logic ld_blk;
	logic [15:0] ld_addr;

	logic busy_any;
	nvmsp_sec_t exec_sec;
	nvmsp_area_t st_area;
	logic [PW-1:0] st_idx;
	logic st_ok;
	logic cmd_wr;
	nvmsp_cmd_t cmd_val;
	logic cmd_go;
	logic cmd_bad;
	logic clr;
	logic next_ld_pend;

	assign arr_data = pbuf;
	assign busy_any = flash_busy_flag || ebusy || !fuse_ok;
	assign exec_sec = sec_of(cpu_pc - FL_BASE, be, ae);
	assign st_area = area_of(cpu_req.addr);
	assign st_idx = cpu_req.addr[PW-1:0]; // [RULE_20]
	// Stores during a busy period are dropped; software must poll first.
	assign st_ok = clk_en && cpu_req.st && !busy_any && st_area != AR_NONE; // [RULE_23]
	assign cmd_wr = clk_en && reg_wr && reg_addr == RA_CMD && op == OP_IDLE && fuse_ok;
	assign cmd_val = nvmsp_cmd_t'(reg_wdata[CMD_W-1:0]);

	always_comb begin
		cmd_go = 1'b0;
		cmd_bad = 1'b0;
		if (cmd_wr) begin
			unique case (cmd_val)
				CMD_CHER: cmd_go = 1'b1;
				CMD_WP, CMD_ERWP, CMD_ER: begin
					if (buf_area != AR_NONE && (cmd_val != CMD_ER || |pmark) &&
						wr_ok(buf_area, buf_sec, exec_sec, app_code_write_protect, reg_dbg, dev_locked))
						cmd_go = 1'b1;
					else
						cmd_bad = 1'b1;
				end
				default: cmd_go = 1'b0;
			endcase
		end
	end

	assign clr = (cmd_wr && cmd_val == CMD_PBC) ||
		(clk_en && op == OP_RUN && arr_done); // [RULE_22]

	// ****************************************
	// Fuse capture after reset release
	// ****************************************
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fuse_ok <= 1'b0;
			be <= 8'h00;
			ae <= 8'h00;
		end else if (clk_en && !fuse_ok) begin
			fuse_ok <= 1'b1;
			be <= fuse_fits(boot_end_fuse) ? boot_end_fuse : BOOT_END_DEF; // [RULE_02] [RULE_07]
			ae <= fuse_fits(app_code_end_fuse) ? app_code_end_fuse : APP_END_DEF; // [RULE_07]
		end
	end

	// ****************************************
	// Protection bits: set only, cleared by reset
	// ****************************************
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lock <= 1'b0;
			app_code_write_protect <= 1'b0;
			fetch_block <= 1'b0;
		end else if (clk_en) begin
			if (reg_wr && reg_addr == RA_PROT) begin
				if (reg_wdata[PB_LOCK] && !reg_dbg && exec_sec == SEC_BOOT)
					lock <= 1'b1; // [RULE_12]
				if (reg_wdata[PB_APP_CODE_WRITE_PROTECT])
					app_code_write_protect <= 1'b1; // [RULE_13]
			end
			fetch_block <= lock && exec_sec != SEC_BOOT; // [RULE_12]
		end
	end

	// ****************************************
	// Operation sequencing
	// ****************************************
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			op <= OP_IDLE;
			flash_busy_flag <= 1'b0;
			ebusy <= 1'b0;
			werr <= 1'b0;
			arr_req <= '0;
			arr_mask <= '0;
		end else if (clk_en) begin
			arr_req.start <= cmd_go;
			if (reg_wr && reg_addr == RA_STAT && reg_wdata[SB_WERR])
				werr <= 1'b0;
			if (cmd_bad)
				werr <= 1'b1;
			if (cmd_go) begin
				op <= OP_RUN;
				arr_req.cmd <= cmd_val;
				arr_req.area <= buf_area;
				arr_req.page_addr <= buf_page;
				flash_busy_flag <= cmd_val == CMD_CHER || buf_area == AR_FLASH;
				ebusy <= cmd_val == CMD_CHER || buf_area != AR_FLASH;
				if (cmd_val == CMD_CHER || buf_area == AR_FLASH)
					arr_mask <= '1; // [RULE_01]
				else
					arr_mask <= pmark; // [RULE_14]
			end else if (op == OP_RUN && arr_done) begin
				op <= OP_IDLE;
				flash_busy_flag <= 1'b0;
				ebusy <= 1'b0;
			end
		end
	end

	// ****************************************
	// Shared page buffer
	// ****************************************
	// One buffer serves every area, so the last stored area owns the next command.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pbuf <= '1; // [RULE_22]
			pmark <= '0;
			buf_area <= AR_NONE;
			buf_sec <= SEC_BOOT;
			buf_page <= 16'h0000;
		end else if (clr) begin
			pbuf <= '1; // [RULE_22]
			pmark <= '0;
		end else if (st_ok) begin
			pbuf[st_idx] <= pbuf[st_idx] & cpu_req.wdata; // [RULE_21]
			pmark[st_idx] <= 1'b1; // [RULE_15]
			buf_area <= st_area; // [RULE_19]
			buf_sec <= sec_of(cpu_req.addr - FL_BASE, be, ae);
			buf_page <= cpu_req.addr;
		end
	end

	// ****************************************
	// Loads with wait states
	// ****************************************
	always_comb begin
		next_ld_pend = ld_pend;
		if (cpu_req.ld && !ld_pend)
			next_ld_pend = 1'b1;
		if (next_ld_pend && !busy_any)
			next_ld_pend = 1'b0;
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ld_pend <= 1'b0;
			ld_addr <= 16'h0000;
			ld_blk <= 1'b0;
			cpu_wait <= 1'b0;
			cpu_ack <= 1'b0;
			cpu_rdata <= RD_NONE;
			arr_rd <= 1'b0;
			arr_raddr <= 16'h0000;
		end else if (clk_en) begin
			ld_pend <= next_ld_pend; // [RULE_18]
			cpu_wait <= next_ld_pend;
			if (cpu_req.ld && !ld_pend)
				ld_addr <= cpu_req.addr;
			arr_rd <= (ld_pend || cpu_req.ld) && !busy_any; // [RULE_18]
			if ((ld_pend || cpu_req.ld) && !busy_any) begin
				arr_raddr <= ld_pend ? ld_addr : cpu_req.addr;
				ld_blk <= lock && exec_sec != SEC_BOOT && area_of(ld_pend ? ld_addr :
					cpu_req.addr) == AR_FLASH && sec_of((ld_pend ? ld_addr :
					cpu_req.addr) - FL_BASE, be, ae) == SEC_BOOT; // [RULE_12]
			end
			cpu_ack <= arr_rd;
			if (arr_rd)
				cpu_rdata <= ld_blk ? RD_NONE : arr_rdata;
		end
	end

	// ****************************************
	// Register read port
	// ****************************************
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= RD_NONE;
		end else if (clk_en) begin
			reg_rdata <= RD_NONE;
			if (reg_rd) begin
				unique case (reg_addr)
					RA_PROT: begin
						reg_rdata[PB_LOCK] <= lock;
						reg_rdata[PB_APP_CODE_WRITE_PROTECT] <= app_code_write_protect;
					end
					RA_STAT: begin
						reg_rdata[SB_FLASH_BUSY_FLAG] <= flash_busy_flag || !fuse_ok;
						reg_rdata[SB_EBUSY] <= ebusy || !fuse_ok;
						reg_rdata[SB_WERR] <= werr;
					end
					RA_BEND: reg_rdata <= be;
					RA_AEND: reg_rdata <= ae;
					default: reg_rdata <= RD_NONE;
				endcase
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence s_start;
		arr_req.start && $past(clk_en) && arr_req.cmd != CMD_CHER;
	endsequence
	sequence s_done;
		clk_en && op == OP_RUN && arr_done;
	endsequence

	a_boot_never_written: assert property (s_start and arr_req.area == AR_FLASH and // [RULE_11]
		!$past(reg_dbg) |-> $past(buf_sec) != SEC_BOOT) else $error("boot section written");
	a_flash_whole_page: assert property (s_start and arr_req.area == AR_FLASH |-> // [RULE_01]
		&arr_mask) else $error("partial flash page");
	a_ee_marked_only: assert property (s_start and arr_req.area != AR_FLASH |-> // [RULE_14]
		arr_mask == $past(pmark)) else $error("unmarked EEPROM bytes touched");
	a_data_no_write: assert property (s_start and !$past(reg_dbg) |-> // [RULE_10]
		$past(exec_sec) != SEC_DATA) else $error("write from data section");
	a_code_wp_holds: assert property (s_start and arr_req.area == AR_FLASH and // [RULE_13]
		$past(buf_sec) == SEC_CODE and !$past(reg_dbg) |-> !$past(app_code_write_protect))
		else $error("protected code section written");
	a_and_merge: assert property (st_ok && !clr |=> arr_data[$past(st_idx)] == // [RULE_21]
		($past(arr_data[st_idx]) & $past(cpu_req.wdata))) else $error("buffer not ANDed");
	a_buf_cleared: assert property (s_done |=> arr_data == '1 && pmark == '0) // [RULE_22]
		else $error("buffer not cleared after operation");
	a_load_waits: assert property (busy_any && clk_en |=> !arr_rd ##1 !cpu_ack) // [RULE_18]
		else $error("load served while busy");
	a_load_answers: assert property (arr_rd && clk_en |=> cpu_ack) // [RULE_18]
		else $error("load not answered");
	a_fuse_range: assert property (fuse_ok |-> 32'(be) * SECT_UNIT <= FLASH_BYTES && // [RULE_07]
		32'(ae) * SECT_UNIT <= FLASH_BYTES) else $error("section end beyond flash");
	a_lock_blocks: assert property (lock && exec_sec != SEC_BOOT && clk_en |=> // [RULE_12]
		fetch_block) else $error("boot lock not applied");
endmodule // nvmsp_top

// *** hdl/nvmsp_pkg.sv ***
/*
 * Shared constants and types for the nonvolatile section and page buffer front end.
 * Assumes a 16-bit byte address space and byte-wide load/store traffic.
 */
package nvmsp_pkg;
	// ****************************************
	// Section layout and address map
	// ****************************************
	localparam int SECT_UNIT = 256;
	localparam logic [15:0] FL_BASE = 16'h8000;
	localparam logic [15:0] EE_BASE = 16'h1400;
	localparam logic [15:0] UR_BASE = 16'h1300;
	// ****************************************
	// Register map and fields
	// ****************************************
	localparam logic [3:0] RA_CMD = 4'h0;
	localparam logic [3:0] RA_PROT = 4'h1;
	localparam logic [3:0] RA_STAT = 4'h2;
	localparam logic [3:0] RA_BEND = 4'h3;
	localparam logic [3:0] RA_AEND = 4'h4;
	localparam int PB_LOCK = 0;
	localparam int PB_APP_CODE_WRITE_PROTECT = 1;
	localparam int SB_FLASH_BUSY_FLAG = 0;
	localparam int SB_EBUSY = 1;
	localparam int SB_WERR = 2;
	localparam int CMD_W = 3;
	localparam logic [7:0] RD_NONE = 8'h00;
	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_WP = 3'h1,
		CMD_ER = 3'h2,
		CMD_ERWP = 3'h3,
		CMD_PBC = 3'h4,
		CMD_CHER = 3'h5
	} nvmsp_cmd_t;
	typedef enum logic [1:0] {
		SEC_BOOT = 2'h0,
		SEC_CODE = 2'h1,
		SEC_DATA = 2'h2
	} nvmsp_sec_t;
	typedef enum logic [1:0] {
		AR_NONE = 2'h0,
		AR_FLASH = 2'h1,
		AR_EE = 2'h2,
		AR_USER = 2'h3
	} nvmsp_area_t;
	typedef struct packed {
		logic ld;
		logic st;
		logic dbg;
		logic [15:0] addr;
		logic [7:0] wdata;
	} nvmsp_cpu_t;
	typedef struct packed {
		logic start;
		nvmsp_cmd_t cmd;
		nvmsp_area_t area;
		logic [15:0] page_addr;
	} nvmsp_arr_req_t;
endpackage

// *** bench/nvmsp_arr_model.sv ***
/*
 * Array back end model: finishes each operation after a programmable latency and
 * answers reads with data made from the address.
 * Assumes the registered start and read pulses of the front end, on the same clock.
 */
`timescale 1ns/1ps
module nvmsp_arr_model import nvmsp_pkg::*; (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire nvmsp_arr_req_t arr_req,
	input wire logic arr_rd,
	input wire logic [15:0] arr_raddr,
	input wire logic [7:0] lat,
	output logic arr_done,
	output logic [7:0] arr_rdata
);
	logic [7:0] cnt;
	logic busy;
	logic [7:0] held;
	logic fresh;
	// ****************************************
	// Operation timing and read data
	// ****************************************
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= 8'h00;
			busy <= 1'b0;
			arr_done <= 1'b0;
		end else begin
			arr_done <= busy && cnt == 8'h00;
			if (arr_req.start) begin
				busy <= 1'b1;
				cnt <= lat;
			end else if (busy && cnt == 8'h00) begin
				busy <= 1'b0;
			end else if (busy) begin
				cnt <= cnt - 8'h01;
			end
		end
	end
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			held <= 8'h00;
			fresh <= 1'b0;
		end else begin
			fresh <= arr_rd;
			if (arr_rd) begin
				held <= arr_raddr[7:0] ^ 8'h5a;
			end
		end
	end
	// Stale data is inverted so a late sample cannot match by luck.
	assign arr_rdata = arr_rd ? (arr_raddr[7:0] ^ 8'h5a) : (fresh ? held : ~held);
endmodule // nvmsp_arr_model

// *** bench/nvmsp_top_test.sv ***
/*
 * Self-checking bench for the nonvolatile front end: register, load and store traffic.
 * Assumes the array model on the far side and an 8 KB flash with 64-byte pages.
 */
`timescale 1ns/1ps
module nvmsp_top_test import nvmsp_pkg::*;;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0, reg_rd = 1'b0, reg_dbg = 1'b0, dev_locked = 1'b0, seen = 1'b0;
	logic clk_en = 1'b1;
	logic [7:0] be = 8'h00, ae = 8'h00, lat = 8'h03, s, reg_rdata, cpu_rdata, arr_rdata;
	nvmsp_cpu_t cpu_req = '0;
	logic [15:0] cpu_pc = 16'h8000, arr_raddr;
	logic cpu_wait, cpu_ack, fetch_block, arr_rd, arr_done;
	nvmsp_arr_req_t arr_req;
	logic [63:0][7:0] arr_data;
	logic [63:0] arr_mask;
	int n_mismatch = 0, n_tests = 0;
	logic [31:0] fz [4] = '{32'h0408_0408, 32'h2108_0008, 32'h0421_0400, 32'h2008_2008};
	logic [48:0] pt [11] = '{
		{8'h04, 8'h08, 16'h8000, 16'h8400, 1'b1},
		{8'h04, 8'h08, 16'h8000, 16'h8900, 1'b1},
		{8'h04, 8'h08, 16'h8400, 16'h8900, 1'b1},
		{8'h04, 8'h08, 16'h8400, 16'h8500, 1'b0},
		{8'h04, 8'h08, 16'h8900, 16'h8a00, 1'b0},
		{8'h04, 8'h08, 16'h8900, 16'h1400, 1'b0},
		{8'h04, 8'h08, 16'h8400, 16'h8000, 1'b0},
		{8'h00, 8'h00, 16'h8000, 16'h9000, 1'b0},
		{8'h04, 8'h00, 16'h9f00, 16'h9e00, 1'b0},
		{8'h08, 8'h04, 16'h8000, 16'h8900, 1'b1},
		{8'h08, 8'h04, 16'h8900, 16'h8a00, 1'b0}};
	always #5 sys_clk = ~sys_clk;
	nvmsp_top #(.FLASH_BYTES(8192), .PAGE_BYTES(64)) uut (.sys_clk, .sys_rst, .clk_en,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_dbg, .reg_rdata, .cpu_req, .cpu_pc,
		.dev_locked, .boot_end_fuse(be), .app_code_end_fuse(ae), .cpu_wait, .cpu_ack,
		.cpu_rdata, .fetch_block, .arr_req, .arr_data, .arr_mask, .arr_rd, .arr_raddr,
		.arr_done, .arr_rdata);
	nvmsp_arr_model model (.sys_clk, .sys_rst, .arr_req, .arr_rd, .arr_raddr, .lat,
		.arr_done, .arr_rdata);
	// ****************************************
	// Access tasks
	// ****************************************
	task automatic chk(input string nm, input logic [511:0] exp, input logic [511:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		s = reg_rdata;
	endtask
	task automatic st(input logic [15:0] a, input logic [7:0] d, input logic dbg);
		cpu_req <= '{1'b0, 1'b1, dbg, a, d};
		@(posedge sys_clk);
		cpu_req.st <= 1'b0;
		#1;
	endtask
	// The count starts in the cycle after the load strobe, so an idle answer gives two.
	task automatic ld(input logic [15:0] a, input logic [7:0] exp, input int lo, input int hi);
		int k;
		cpu_req <= '{1'b1, 1'b0, 1'b0, a, 8'h00};
		seen = 1'b0;
		@(posedge sys_clk);
		cpu_req.ld <= 1'b0;
		#1;
		k = 1;
		while (cpu_ack !== 1'b1 && k < 200) begin
			if (cpu_wait === 1'b1) seen = 1'b1;
			@(posedge sys_clk);
			#1;
			k++;
		end
		chk("load data", exp, cpu_rdata);
		chk("load latency", 1'b1, k >= lo && k <= hi);
	endtask
	task automatic wait_idle;
		int k;
		k = 0;
		s = 8'hff;
		while (s[1:0] !== 2'b00 && k < 100) begin
			rd(RA_STAT);
			k++;
		end
		chk("idle", 2'b00, s[1:0]);
	endtask
	task automatic cmd(input logic [2:0] c, input logic ok);
		wr(RA_CMD, {5'h00, c});
		#1;
		chk("start", ok, arr_req.start);
		if (!ok) begin
			rd(RA_STAT);
			chk("write error", 1'b1, s[SB_WERR]);
			wr(RA_STAT, 8'h04);
		end
		wait_idle();
	endtask
	task automatic do_reset(input logic [7:0] b, input logic [7:0] a);
		sys_rst <= 1'b1;
		be <= b;
		ae <= a;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask
	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		@(posedge sys_clk);
		do_reset(8'h04, 8'h08);
		chk("buffer reset", {512{1'b1}}, arr_data);
		foreach (fz[i]) begin
			do_reset(fz[i][31:24], fz[i][23:16]);
			rd(RA_BEND);
			chk("boot end", fz[i][15:8], s);
			rd(RA_AEND);
			chk("app end", fz[i][7:0], s);
		end
		foreach (pt[i]) begin
			do_reset(pt[i][48:41], pt[i][40:33]);
			cpu_pc <= pt[i][32:17];
			st(pt[i][16:1], 8'h3c, 1'b0);
			cmd(CMD_WP, pt[i][0]);
		end
		cpu_pc <= 16'h8000;
		st(16'h8903, 8'h0f, 1'b0);
		st(16'h8943, 8'hf5, 1'b0);
		chk("and merge", 8'h05, arr_data[3]);
		wr(RA_CMD, {5'h00, CMD_PBC});
		#1;
		chk("buffer clear", {512{1'b1}}, arr_data);
		st(16'h8905, 8'ha5, 1'b0);
		wr(RA_CMD, {5'h00, CMD_WP});
		#1;
		chk("flash mask", {64{1'b1}}, arr_mask);
		chk("flash area", AR_FLASH, arr_req.area);
		wait_idle();
		chk("buffer after op", {512{1'b1}}, arr_data);
		lat <= 8'h28;
		st(16'h1402, 8'h11, 1'b0);
		st(16'h1407, 8'h22, 1'b0);
		wr(RA_CMD, {5'h00, CMD_WP});
		#1;
		chk("eeprom mask", 64'h84, arr_mask);
		chk("eeprom area", AR_EE, arr_req.area);
		chk("eeprom page", 16'h1407, arr_req.page_addr);
		chk("eeprom command", CMD_WP, arr_req.cmd);
		ld(16'h8010, 8'h10 ^ 8'h5a, 30, 199);
		chk("load wait", 1'b1, seen);
		wait_idle();
		lat <= 8'h03;
		ld(16'h8011, 8'h11 ^ 8'h5a, 2, 2);
		do_reset(8'h04, 8'h08);
		wr(RA_PROT, 8'h02);
		st(16'h8400, 8'h00, 1'b0);
		cmd(CMD_WP, 1'b0);
		st(16'h8900, 8'h00, 1'b0);
		cmd(CMD_WP, 1'b1);
		wr(RA_PROT, 8'h01);
		#1;
		chk("lock in boot", 1'b0, fetch_block);
		cpu_pc <= 16'h8400;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("lock outside", 1'b1, fetch_block);
		ld(16'h8001, 8'h00, 2, 2);
		ld(16'h8401, 8'h01 ^ 8'h5a, 2, 2);
		// A store seen while the clock enable is low must leave the buffer untouched.
		clk_en <= 1'b0;
		st(16'h8902, 8'h00, 1'b0);
		clk_en <= 1'b1;
		chk("frozen store", 8'hff, arr_data[2]);
		cmd(CMD_ER, 1'b0);
		st(16'h8905, 8'h00, 1'b0);
		cmd(CMD_ERWP, 1'b1);
		cmd(CMD_CHER, 1'b1);
		chk("chip erase", CMD_CHER, arr_req.cmd);
		chk("chip erase mask", {64{1'b1}}, arr_mask);
		dev_locked <= 1'b1;
		reg_dbg <= 1'b1;
		st(16'h1305, 8'h77, 1'b1);
		cmd(CMD_WP, 1'b1);
		chk("user area", AR_USER, arr_req.area);
		st(16'h8905, 8'h00, 1'b1);
		cmd(CMD_WP, 1'b0);
		finish_test();
	end
	initial begin
		#500000;
		n_mismatch++;
		finish_test();
	end
endmodule // nvmsp_top_test
